// >>> design/gdfp_pkg.sv
// Purpose: shared constants for the gate driver fault protection block
// Assumes: 40 MHz core clock, Avalon-MM register access
// Notes:   byte addresses, one 32-bit word per register
package gdfp_pkg;
	// -------------------------------------------------------------
	// register map
	// -------------------------------------------------------------
	localparam logic [3:0]  CTRL_ADDR   = 4'h0;
	localparam logic [3:0]  CLEAR_ADDR  = 4'h4;
	localparam logic [3:0]  STATUS_ADDR = 4'h8;
	// control fields
	localparam int          MASK_OC_BIT    = 0;
	localparam int          MASK_PERR_BIT  = 1;
	localparam int          MASK_DESAT_BIT = 2;
	localparam int          MASK_UV_BIT    = 3;
	localparam int          DESAT_SD_BIT   = 4;
	localparam int          PERR_SD_BIT    = 5;
	localparam int          DEAD_LSB       = 8;
	localparam int          BLANK_LSB      = 16;
	localparam logic [7:0]  DEAD_RESET     = 8'h08;
	localparam logic [7:0]  BLANK_RESET    = 8'h10;
	localparam logic [5:0]  MASK_RESET     = 6'h00;
	// clear fields
	localparam int          CLR_A_BIT      = 0;
	localparam int          CLR_B_BIT      = 1;
	// status fields
	localparam int          ST_OC_BIT      = 0;
	localparam int          ST_PERR_BIT    = 1;
	localparam int          ST_DESAT_BIT   = 2;
	localparam int          ST_UV_BIT      = 3;
	localparam int          ST_PHASE_LSB   = 4;
	localparam int          ST_PUMP_BIT    = 7;
	localparam int          ST_OCLIVE_BIT  = 8;
	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_HZ         = 40000000;
	localparam int CLK_PERIOD_PS  = 25000;
	localparam int DESAT_FILT_NS  = 1000;
	localparam int UV_FILT_NS     = 700;
	localparam int UV_STRONG_NS   = 8000;
	localparam int PUMP_HZ        = 130000;
	localparam int DESAT_CYC =
		(DESAT_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int UV_FILT_CYC =
		(UV_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int UV_STRONG_CYC = (UV_STRONG_NS * 1000) / CLK_PERIOD_PS;
	localparam int PUMP_HALF_CYC = CLK_HZ / (2 * PUMP_HZ);
endpackage : gdfp_pkg

// >>> design/gate_driver_fault_protection.sv
// Purpose: fault protection and gate steering for a three phase predriver
// Assumes: comparator and command pins are asynchronous to clk
// Notes:
// Notes on behaviour
// RULE1: overcurrent comparator latches fault and flag output
// RULE2: latched overcurrent in status, masked interrupt
// RULE3: interrupt holds until fault gone and clear A
// RULE4: deadtime starts at low off, then high on
// RULE5: desaturation after blanking initiates fault
// RULE6: desaturation registered after 1.0 us filter
// RULE7: registered desaturation turns all gates off
// RULE8: condition clearing early restarts the filter
// RULE9: status readable, mask and shutdown disable honoured
// RULE10: high side phase error, also desaturation
// RULE11: low side phase error after deadtime, blanking
// RULE12: phase error ORs per phase and overall
// RULE13: phase error interrupt held until clear B
// RULE14: undervoltage filtered about 700 ns first
// RULE15: undervoltage strong turn off then hold off
// RULE16: on recovery low follows, high waits init
// RULE17: high gate floats until low turns off
// RULE18: hold off on low logic, reset, cutoff
// RULE19: charge pump enable with hysteresis
// RULE20: charge pump switched at 130 kHz
// RULE21: any fault demands fresh initialization; code demands it only after a shutdown or undervoltage, not after overcurrent
// RULE22: host toggles low then high per phase
// RULE23: comparator inputs synchronised before use
`timescale 1ns/1ps
module gate_driver_fault_protection
	import gdfp_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// comparators and commands, asynchronous
	input  wire logic        sense_amp_over,
	input  wire logic [2:0]  desat_cmp,
	input  wire logic [2:0]  phase_node_sense,
	input  wire logic        gate_supply_uv,
	input  wire logic        gate_supply_cutoff_level,
	input  wire logic        logic_supply_low,
	input  wire logic        pump_below_reg,
	input  wire logic        pump_above_hyst,
	input  wire logic [2:0]  high_side_cmd_in,
	input  wire logic [2:0]  low_side_cmd_in,
	// gate and status outputs
	output logic      [2:0]  high_gate_drive,
	output logic      [2:0]  high_gate_oe,
	output logic      [2:0]  low_gate_drive,
	output logic             strong_off,
	output logic             hold_off,
	output logic             overcurrent_flag_out,
	output logic             irq,
	output logic             pump_en,
	output logic             pump_clk
);
	// -------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------
	localparam int NSYNC = 18;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic [5:0]       cmd_prev;
	logic             oc_s, uv_s, cut_s, vdd_s, plo_s, phi_s;
	logic [2:0]       desat_s, phase_s, hs_s, ls_s;

	// two flops per pin, first stage read only by second [RULE23]
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= {sense_amp_over, desat_cmp, phase_node_sense,
				gate_supply_uv, gate_supply_cutoff_level,
				logic_supply_low, pump_below_reg, pump_above_hyst,
				high_side_cmd_in, low_side_cmd_in};
			sync2 <= sync1;
		end

	assign {oc_s, desat_s, phase_s, uv_s, cut_s, vdd_s, plo_s, phi_s,
		hs_s, ls_s} = sync2;

	// previous command levels for edge detection
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			cmd_prev <= '0;
		else
			cmd_prev <= {hs_s, ls_s};

	// -------------------------------------------------------------
	// control registers
	// -------------------------------------------------------------
	logic [5:0] ctrl_bits;
	logic [7:0] dead_cyc;
	logic [7:0] blank_cyc;
	logic       acc_wr, acc_rd, clr_a, clr_b;
	logic       st_oc, st_desat, uv_q, uv_d;
	logic [2:0] hs_perr, ls_perr, perr_ph;
	logic [2:0] hs_on, ls_on, hs_armed;
	logic       perr_any, kill;

	assign acc_wr = write && !waitrequest;
	assign acc_rd = read && !waitrequest;
	assign clr_a  = acc_wr && address == CLEAR_ADDR && writedata[CLR_A_BIT];
	assign clr_b  = acc_wr && address == CLEAR_ADDR && writedata[CLR_B_BIT];

	// one wait cycle per access, answer from a flop
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((read || write) && waitrequest);

	// control word: masks, shutdown disables, timing [RULE9]
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			ctrl_bits <= MASK_RESET;
			dead_cyc  <= DEAD_RESET;
			blank_cyc <= BLANK_RESET;
		end
		else if (acc_wr && address == CTRL_ADDR)
		begin
			ctrl_bits <= writedata[5:0];
			dead_cyc  <= writedata[DEAD_LSB +: 8];
			blank_cyc <= writedata[BLANK_LSB +: 8];
		end

	// read data loaded as waitrequest drops; unmapped reads zero
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			readdata <= '0;
		else if (read && waitrequest)
		begin
			readdata <= '0;
			if (address == CTRL_ADDR)
				readdata <= {8'h00, blank_cyc, dead_cyc, 2'b00,
					ctrl_bits};
			else if (address == STATUS_ADDR)
			begin
				readdata[ST_OC_BIT]    <= st_oc;
				readdata[ST_PERR_BIT]  <= perr_any;
				readdata[ST_DESAT_BIT] <= st_desat;
				readdata[ST_UV_BIT]    <= uv_q;
				readdata[ST_PHASE_LSB +: 3] <= perr_ph;
				readdata[ST_PUMP_BIT]  <= pump_en;
				readdata[ST_OCLIVE_BIT] <= oc_s;
			end
		end

	// -------------------------------------------------------------
	// overcurrent and interrupt
	// -------------------------------------------------------------
	// live condition sets, so clear only works once it is gone
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			st_oc <= 1'b0;
		else if (oc_s)
			st_oc <= 1'b1;                         // [RULE1]
		else if (clr_a)
			st_oc <= 1'b0;                         // [RULE3]

	assign perr_ph  = hs_perr | ls_perr;               // [RULE12]
	assign perr_any = |perr_ph;                        // [RULE12]

	// flag pin and masked level interrupt
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			overcurrent_flag_out <= 1'b0;
			irq                  <= 1'b0;
		end
		else
		begin
			overcurrent_flag_out <= st_oc;                 // [RULE1]
			irq <= (st_oc && ctrl_bits[MASK_OC_BIT])       // [RULE2]
				|| (perr_any && ctrl_bits[MASK_PERR_BIT])  // [RULE13]
				|| (st_desat && ctrl_bits[MASK_DESAT_BIT])
				|| (uv_q && ctrl_bits[MASK_UV_BIT]);
		end

	// -------------------------------------------------------------
	// deadtime, blanking, phase and desaturation checks
	// -------------------------------------------------------------
	logic [7:0] dt_cnt [3];
	logic [7:0] bl_cnt [3];
	logic [5:0] df_cnt [3];
	logic [2:0] pend_hs, pend_ls, dcond, dexpire;

	// shutdown unless host disabled it for that fault [RULE9]
	assign kill = (st_desat && !ctrl_bits[DESAT_SD_BIT])
		|| (perr_any && !ctrl_bits[PERR_SD_BIT]);

	// high side on, blanking over, desat seen or node not up [RULE5] [RULE10]
	assign dcond = hs_on & {bl_cnt[2] == 8'h00, bl_cnt[1] == 8'h00,
		bl_cnt[0] == 8'h00} & (desat_s | ~phase_s);
	always_comb
		for (int p = 0; p < 3; p++)
			dexpire[p] = dcond[p]
				&& df_cnt[p] == 6'(DESAT_CYC - 1);   // [RULE6]

	// per phase steering; edge on a command input selects a side
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			hs_on    <= '0;
			ls_on    <= '0;
			pend_hs  <= '0;
			pend_ls  <= '0;
			hs_armed <= '0;
			for (int p = 0; p < 3; p++)
			begin
				dt_cnt[p] <= '0;
				bl_cnt[p] <= '0;
			end
		end
		else
			for (int p = 0; p < 3; p++)
			begin
				if (dt_cnt[p] != 8'h00)
					dt_cnt[p] <= dt_cnt[p] - 8'h01;
				if (bl_cnt[p] != 8'h00)
					bl_cnt[p] <= bl_cnt[p] - 8'h01;
				if (kill || uv_q)
				begin
					// fault forces off and demands re-init [RULE7] [RULE21]
					hs_on[p]    <= 1'b0;
					ls_on[p]    <= 1'b0;
					pend_hs[p]  <= 1'b0;
					pend_ls[p]  <= 1'b0;
					hs_armed[p] <= 1'b0;
				end
				else if (uv_d && ls_s[p])
				begin
					// supply back: low follows its level at once [RULE16]
					ls_on[p] <= 1'b1;
				end
				else if (hs_s[p] && !cmd_prev[3+p])
				begin
					// low off now, deadtime from that moment [RULE4]
					ls_on[p]   <= 1'b0;
					pend_ls[p] <= 1'b0;
					pend_hs[p] <= 1'b1;
					if (ls_on[p])
						dt_cnt[p] <= dead_cyc;
				end
				else if (ls_s[p] && !cmd_prev[p])
				begin
					hs_on[p]   <= 1'b0;
					pend_hs[p] <= 1'b0;
					pend_ls[p] <= 1'b1;
					if (hs_on[p])
						dt_cnt[p] <= dead_cyc;
				end
				else if (!hs_s[p] && cmd_prev[3+p])
				begin
					// turning a side off starts the deadtime [RULE4]
					if (hs_on[p])
						dt_cnt[p] <= dead_cyc;
					hs_on[p]   <= 1'b0;
					pend_hs[p] <= 1'b0;
				end
				else if (!ls_s[p] && cmd_prev[p])
				begin
					// low side turned off by command arms high [RULE17]
					if (ls_on[p])
					begin
						hs_armed[p] <= 1'b1;
						dt_cnt[p]   <= dead_cyc;   // [RULE4]
					end
					ls_on[p]   <= 1'b0;
					pend_ls[p] <= 1'b0;
				end
				else if (dt_cnt[p] == 8'h00 && pend_hs[p])
				begin
					hs_on[p]   <= 1'b1;                // [RULE4]
					pend_hs[p] <= 1'b0;
					bl_cnt[p]  <= blank_cyc | 8'h01;
				end
				else if (dt_cnt[p] == 8'h00 && pend_ls[p])
				begin
					ls_on[p]   <= 1'b1;
					pend_ls[p] <= 1'b0;
					bl_cnt[p]  <= blank_cyc | 8'h01;
				end
			end

	// phase errors at the end of blanking, cleared by clear B
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			hs_perr <= '0;
			ls_perr <= '0;
		end
		else
			for (int p = 0; p < 3; p++)
			begin
				if (hs_on[p] && bl_cnt[p] == 8'h01 && !phase_s[p])
					hs_perr[p] <= 1'b1;            // [RULE10]
				else if (clr_b)
					hs_perr[p] <= 1'b0;            // [RULE13]
				if (ls_on[p] && bl_cnt[p] == 8'h01 && phase_s[p])
					ls_perr[p] <= 1'b1;            // [RULE11]
				else if (clr_b)
					ls_perr[p] <= 1'b0;
			end

	// digital filter; a gap in the condition restarts it
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			for (int p = 0; p < 3; p++)
				df_cnt[p] <= '0;
			st_desat <= 1'b0;
		end
		else
		begin
			for (int p = 0; p < 3; p++)
				if (!dcond[p] || dexpire[p])
					df_cnt[p] <= '0;               // [RULE8]
				else
					df_cnt[p] <= df_cnt[p] + 6'h01;
			if (|dexpire)
				st_desat <= 1'b1;                  // [RULE6]
			else if (clr_b)
				st_desat <= 1'b0;
		end

	// -------------------------------------------------------------
	// gate supply undervoltage
	// -------------------------------------------------------------
	logic [4:0] uvf_cnt;
	logic [8:0] st_cnt;

	// filter rejects short dips before acting [RULE14]
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			uvf_cnt <= '0;
			uv_q    <= 1'b0;
			st_cnt  <= '0;
			uv_d    <= 1'b0;
		end
		else
		begin
			// delayed copy marks the cycle after recovery
			uv_d <= uv_q;
			if (!uv_s)
			begin
				uvf_cnt <= '0;
				uv_q    <= 1'b0;                   // [RULE16]
			end
			else if (!uv_q && uvf_cnt == 5'(UV_FILT_CYC - 1))
			begin
				uv_q   <= 1'b1;                    // [RULE14]
				st_cnt <= 9'(UV_STRONG_CYC);       // [RULE15]
			end
			else if (!uv_q)
				uvf_cnt <= uvf_cnt + 5'h01;
			if (st_cnt != 9'h000 && !(uv_s && !uv_q
				&& uvf_cnt == 5'(UV_FILT_CYC - 1)))
				st_cnt <= st_cnt - 9'h001;
		end

	// -------------------------------------------------------------
	// gate outputs and hold off
	// -------------------------------------------------------------
	// low follows input at once; high needs init and drives only then
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			high_gate_drive <= '0;
			high_gate_oe    <= '0;
			low_gate_drive  <= '0;
			strong_off      <= 1'b0;
			hold_off        <= 1'b1;               // [RULE18]
		end
		else
		begin
			low_gate_drive  <= ls_on;              // [RULE16]
			high_gate_drive <= hs_on & hs_armed;   // [RULE21]
			// floats until armed, driven low during faults [RULE17]
			high_gate_oe    <= hs_armed | {3{kill || uv_q}};
			strong_off      <= kill || (uv_q && st_cnt != 9'h000);
			// weak pull-down after strong phase ends [RULE15]
			hold_off        <= vdd_s || cut_s      // [RULE18]
				|| (uv_q && st_cnt == 9'h000);
		end

	// -------------------------------------------------------------
	// charge pump
	// -------------------------------------------------------------
	logic [7:0] pump_cnt;

	// hysteresis from two thresholds avoids chatter [RULE19]
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			pump_en <= 1'b0;
		else if (plo_s)
			pump_en <= 1'b1;
		else if (phi_s)
			pump_en <= 1'b0;

	// square wave at the pump rate while enabled [RULE20]
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			pump_cnt <= '0;
			pump_clk <= 1'b0;
		end
		else if (!pump_en)
		begin
			pump_cnt <= '0;
			pump_clk <= 1'b0;
		end
		else if (pump_cnt == 8'(PUMP_HALF_CYC - 1))
		begin
			pump_cnt <= '0;
			pump_clk <= !pump_clk;
		end
		else
			pump_cnt <= pump_cnt + 8'h01;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	oc_latch_a: assert property (oc_s |=> st_oc ##1 overcurrent_flag_out)
		else $error("overcurrent not latched"); // [RULE1]
	oc_irq_a: assert property (st_oc && ctrl_bits[MASK_OC_BIT] |=> irq)
		else $error("masked overcurrent gave no irq"); // [RULE2]
	irq_hold_a: assert property (st_oc && oc_s && clr_a |=> st_oc)
		else $error("overcurrent cleared while present"); // [RULE3]
	no_overlap_a: assert property (!(hs_on[0] && ls_on[0]))
		else $error("both sides on in phase 0"); // [RULE4]
	desat_filt_a: assert property ($rose(st_desat) |->
		$past(df_cnt[0]) == 6'(DESAT_CYC - 1)
		|| $past(df_cnt[1]) == 6'(DESAT_CYC - 1)
		|| $past(df_cnt[2]) == 6'(DESAT_CYC - 1))
		else $error("desat registered before filter"); // [RULE6]
	desat_kill_a: assert property (st_desat && !ctrl_bits[DESAT_SD_BIT]
		|=> ##1 high_gate_drive == 3'b000 && low_gate_drive == 3'b000)
		else $error("gates on after desat"); // [RULE7]
	filt_reset_a: assert property (!dcond[0] |=> df_cnt[0] == 6'h00)
		else $error("filter not restarted"); // [RULE8]
	uv_strong_a: assert property ($rose(uv_q) |=> strong_off[*8])
		else $error("no strong turn off on undervoltage"); // [RULE15]
	uv_filter_a: assert property ($rose(uv_q) |-> $past(uv_s, 2))
		else $error("undervoltage acted unfiltered"); // [RULE14]
	hold_vdd_a: assert property (vdd_s |=> hold_off)
		else $error("hold off missing on low logic"); // [RULE18]
	pump_hyst_a: assert property ($fell(pump_en) |-> $past(phi_s))
		else $error("pump off without hysteresis"); // [RULE19]

	desat_seen_c: cover property ($rose(st_desat));
	uv_cycle_c: cover property ($rose(uv_q) ##[1:400] $fell(uv_q));
	irq_clear_c: cover property (irq ##1 clr_a ##[1:4] !irq);
endmodule : gate_driver_fault_protection

// >>> tb/fet_stage_model.sv
// Purpose: far side model of three half bridges and their comparators
// Assumes: gates act at once on the phase node
// Notes:   fault_gnd shorts a node low, fault_sup holds it high
`timescale 1ns/1ps
module fet_stage_model
(
	// gate side
	input  wire logic [2:0] high_gate_drive,
	input  wire logic [2:0] high_gate_oe,
	input  wire logic [2:0] low_gate_drive,
	// injected faults
	input  wire logic [2:0] fault_gnd,
	input  wire logic [2:0] fault_sup,
	// comparators
	output logic      [2:0] phase_node_sense,
	output logic      [2:0] desat_cmp
);
	// ---------------------------------------------------------
	// node and comparators
	// ---------------------------------------------------------
	logic [2:0] high_on;
	// a floated node bleeds to ground, never a stale high
	assign high_on = high_gate_drive & high_gate_oe;
	assign phase_node_sense = fault_sup
		| (high_on & ~fault_gnd & ~low_gate_drive);
	// drop across the high fet only shows while it conducts
	assign desat_cmp = high_on & ~phase_node_sense;
endmodule : fet_stage_model

// >>> tb/tb_gate_driver_fault_protection.sv
// Purpose: self-checking bench for the fault protection block
// Assumes: bus tasks start right after a rising clock edge
// Notes:   fixed waits follow the sync and filter figures of the block
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module tb_gate_driver_fault_protection
	import gdfp_pkg::*;
;
	// ---------------------------------------------------------
	// signals
	// ---------------------------------------------------------
	logic        clk, arst_n, read, write, waitrequest;
	logic [3:0]  address;
	logic [31:0] writedata, readdata, rd, base;
	logic        sense_amp_over, gate_supply_uv, gate_supply_cutoff_level;
	logic        logic_supply_low, pump_below_reg, pump_above_hyst;
	logic [2:0]  desat_cmp, phase_node_sense, high_side_cmd_in;
	logic [2:0]  low_side_cmd_in, high_gate_drive, high_gate_oe;
	logic [2:0]  low_gate_drive, fault_gnd, fault_sup;
	logic        strong_off, hold_off, overcurrent_flag_out, irq;
	logic        pump_en, pump_clk;
	int          n_fail, tests_run, cycles, cnt;

	gate_driver_fault_protection dut (.clk(clk), .arst_n(arst_n),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sense_amp_over(sense_amp_over),
		.desat_cmp(desat_cmp), .phase_node_sense(phase_node_sense),
		.gate_supply_uv(gate_supply_uv),
		.gate_supply_cutoff_level(gate_supply_cutoff_level),
		.logic_supply_low(logic_supply_low),
		.pump_below_reg(pump_below_reg), .pump_above_hyst(pump_above_hyst),
		.high_side_cmd_in(high_side_cmd_in),
		.low_side_cmd_in(low_side_cmd_in),
		.high_gate_drive(high_gate_drive), .high_gate_oe(high_gate_oe),
		.low_gate_drive(low_gate_drive), .strong_off(strong_off),
		.hold_off(hold_off), .overcurrent_flag_out(overcurrent_flag_out),
		.irq(irq), .pump_en(pump_en), .pump_clk(pump_clk));

	fet_stage_model bridge (.high_gate_drive(high_gate_drive),
		.high_gate_oe(high_gate_oe), .low_gate_drive(low_gate_drive),
		.fault_gnd(fault_gnd), .fault_sup(fault_sup),
		.phase_node_sense(phase_node_sense), .desat_cmp(desat_cmp));

	// ---------------------------------------------------------
	// clock, timeout and helpers
	// ---------------------------------------------------------
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// run needs about 1200 cycles; the ceiling leaves wide room
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_fail++;
			report_and_stop();
		end
	end

	task report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// request held until waitrequest is seen low, then one idle edge
	task bus_write(input logic [3:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
		@(posedge clk);
	endtask : bus_write

	task bus_read(input logic [3:0] a, output logic [31:0] d);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
		@(posedge clk);
	endtask : bus_read

	// low on, low off, then high command inside the deadtime
	task pwm_high(input int p);
		low_side_cmd_in[p] <= 1'b1;
		tick(10);
		`CHK("low on", 1'b1, low_gate_drive[p]);
		low_side_cmd_in[p] <= 1'b0;
		tick(2);
		high_side_cmd_in[p] <= 1'b1;
		tick(6);
		`CHK("dead", 2'b00, {high_gate_drive[p], low_gate_drive[p]});
	endtask : pwm_high

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial
	begin
		{arst_n, read, write, sense_amp_over, gate_supply_uv} = '0;
		{gate_supply_cutoff_level, logic_supply_low} = '0;
		{pump_below_reg, pump_above_hyst, address, writedata} = '0;
		{high_side_cmd_in, low_side_cmd_in, fault_gnd, fault_sup} = '0;
		base = {8'h00, BLANK_RESET, DEAD_RESET, 8'h00};
		tick(10);
		`CHK("hold in reset", 1'b1, hold_off);
		arst_n <= 1'b1;
		tick(6);
		`CHK("hold released", 1'b0, hold_off);
		bus_read(CTRL_ADDR, rd);
		`CHK("ctrl reset", base, rd);
		bus_write(STATUS_ADDR, 32'hFFFFFFFF);
		bus_read(STATUS_ADDR, rd);
		`CHK("status reset", 32'h0, rd);
		bus_read(4'hC, rd);
		`CHK("unmapped", 32'h0, rd);
		// overcurrent: latch, mask, clear only once gone
		sense_amp_over <= 1'b1;
		tick(6);
		`CHK("oc flag", 1'b1, overcurrent_flag_out);
		`CHK("irq masked", 1'b0, irq);
		bus_read(STATUS_ADDR, rd);
		`CHK("oc status", 32'h101, rd);
		bus_write(CTRL_ADDR, base | 32'h1);
		tick(3);
		`CHK("oc irq", 1'b1, irq);
		bus_write(CLEAR_ADDR, 32'h1);
		tick(3);
		`CHK("clear early", 1'b1, irq);
		sense_amp_over <= 1'b0;
		tick(6);
		`CHK("irq sticky", 1'b1, irq);
		bus_read(STATUS_ADDR, rd);
		`CHK("oc latched", 32'h1, rd);
		bus_write(CLEAR_ADDR, 32'h1);
		tick(3);
		`CHK("oc cleared", 2'b00, {irq, overcurrent_flag_out});
		// desat pulse shorter than the filter is dropped
		bus_write(CTRL_ADDR, base | 32'h26);
		pwm_high(1);
		tick(40);
		fault_gnd[1] <= 1'b1;
		tick(20);
		fault_gnd[1] <= 1'b0;
		tick(60);
		bus_read(STATUS_ADDR, rd);
		`CHK("desat dropped", 1'b0, rd[ST_DESAT_BIT]);
		`CHK("phase1 runs", 1'b1, high_gate_drive[1]);
		bus_write(CLEAR_ADDR, 32'h2);
		// real short on phase 0 shuts every phase down
		fault_gnd[0] <= 1'b1;
		pwm_high(0);
		tick(100);
		bus_read(STATUS_ADDR, rd);
		`CHK("desat status", 7'h16, rd[6:0]);
		`CHK("all off", 6'h0, {high_gate_drive, low_gate_drive});
		`CHK("desat irq", 1'b1, irq);
		fault_gnd[0] <= 1'b0;
		high_side_cmd_in <= 3'h0;
		tick(6);
		bus_write(CLEAR_ADDR, 32'h2);
		tick(3);
		`CHK("irq b clear", 1'b0, irq);
		high_side_cmd_in[0] <= 1'b1;
		tick(12);
		`CHK("needs init", 2'b00, {high_gate_drive[0], high_gate_oe[0]});
		high_side_cmd_in[0] <= 1'b0;
		// low side phase error with shutdown disabled
		bus_write(CTRL_ADDR, base | 32'h36);
		fault_sup[2] <= 1'b1;
		low_side_cmd_in[2] <= 1'b1;
		tick(50);
		bus_read(STATUS_ADDR, rd);
		`CHK("ls phase err", 7'h42, rd[6:0]);
		`CHK("no shutdown", 1'b1, low_gate_drive[2]);
		`CHK("perr irq", 1'b1, irq);
		fault_sup[2] <= 1'b0;
		low_side_cmd_in[2] <= 1'b0;
		tick(6);
		bus_write(CLEAR_ADDR, 32'h2);
		tick(3);
		`CHK("perr cleared", 1'b0, irq);
		// undervoltage: glitch ignored, strong phase, then weak hold
		low_side_cmd_in[0] <= 1'b1;
		gate_supply_uv <= 1'b1;
		tick(20);
		`CHK("uv filtered", 1'b0, strong_off);
		gate_supply_uv <= 1'b0;
		tick(10);
		`CHK("uv glitch", 2'b01, {strong_off, low_gate_drive[0]});
		gate_supply_uv <= 1'b1;
		tick(40);
		`CHK("uv strong", 2'b10, {strong_off, low_gate_drive[0]});
		tick(UV_STRONG_CYC - 20);
		`CHK("strong held", 1'b1, strong_off);
		tick(20);
		`CHK("weak hold", 2'b01, {strong_off, hold_off});
		bus_read(STATUS_ADDR, rd);
		`CHK("uv status", 1'b1, rd[ST_UV_BIT]);
		gate_supply_uv <= 1'b0;
		tick(6);
		`CHK("low follows", 2'b10, {low_gate_drive[0], hold_off});
		`CHK("high floats", 1'b0, high_gate_oe[0]);
		low_side_cmd_in[0] <= 1'b0;
		tick(6);
		high_side_cmd_in[0] <= 1'b1;
		tick(20);
		`CHK("high back", 2'b11, {high_gate_drive[0], high_gate_oe[0]});
		high_side_cmd_in[0] <= 1'b0;
		// hold-off from cutoff level and from low logic supply
		for (int i = 0; i < 2; i++)
		begin
			gate_supply_cutoff_level <= (i == 0);
			logic_supply_low <= (i == 1);
			tick(6);
			`CHK("hold on", 1'b1, hold_off);
			{gate_supply_cutoff_level, logic_supply_low} <= 2'b00;
			tick(6);
			`CHK("hold off", 1'b0, hold_off);
		end
		// charge pump hysteresis and switching rate
		pump_below_reg <= 1'b1;
		tick(6);
		`CHK("pump on", 1'b1, pump_en);
		pump_below_reg <= 1'b0;
		tick(6);
		`CHK("pump hyst", 1'b1, pump_en);
		for (int k = 0; k < 2; k++)
		begin
			rd[0] = pump_clk;
			cnt = 0;
			while (pump_clk === rd[0] && cnt < 400)
			begin
				tick(1);
				cnt++;
			end
		end
		`CHK("pump half", PUMP_HALF_CYC, cnt);
		pump_above_hyst <= 1'b1;
		tick(6);
		`CHK("pump off", 1'b0, pump_en);
		report_and_stop();
	end
endmodule : tb_gate_driver_fault_protection
